// >>> hdl/scan_trigger_and_error_queue.sv
// Error queue and scan trigger controller for one switchbox
`timescale 1ns/1ps

// Overview of operation
// RL1: Each detected error pushes number and message
// RL2: Query returns and removes oldest entry
// RL3: Empty queue query returns zero, no error
// RL4: Clear status empties queue at once
// RL5: Queue holds thirty entries per switchbox
// RL6: Overflow replaces last slot with overflow error
// RL7: Software trigger only with bus or hold
// RL8: Host defines list and arms before trigger
// RL9: Triggering never changes source selection
// RL10: Five sources including eight backplane lines
// RL11: Source takes effect only at arm
// RL12: External input granted to first requester
// RL13: Grant held until bus, hold or immediate
// RL14: Busy external request rejected and logged
// RL15: Host uses bus trigger command with bus
// RL16: Enabled output pulses on each channel close
// RL17: One trigger output enabled at a time
// RL18: Reset command selects immediate source
// RL19: Arm closes first channel, trigger advances one
// RL20: Immediate source advances without waiting
module scan_trigger_and_error_queue
  import scan_trig_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Host commands, one-cycle pulses, with their arguments
  input  wire logic              rst_cmd_i,
  input  wire logic              cls_cmd_i,
  input  wire logic              err_query_i,
  input  wire logic              err_push_i,
  input  wire err_entry_t        err_entry_i,
  input  wire logic              src_write_i,
  input  wire src_sel_t          src_sel_i,
  input  wire logic              scan_arm_cmd_i,
  input  wire logic              sw_trig_i,
  input  wire logic              bus_trig_i,
  input  wire logic              abort_i,
  input  wire logic [CHAN_W-1:0] list_len_i,
  input  wire logic              out_write_i,
  input  wire trig_out_sel_t     out_sel_i,
  // Shared external input arbitration
  input  wire logic [BOX_W-1:0]  box_id_i,
  input  wire logic              ext_owned_i,
  input  wire logic [BOX_W-1:0]  ext_owner_i,
  // Trigger pins from outside
  input  wire logic              ext_trig_pin_i,
  input  wire logic [7:0]        backplane_line_source_i,
  // Error answer
  output logic                   err_valid_o,
  output err_entry_t             err_entry_o,
  output logic [ERR_CNT_W-1:0]   err_count_o,
  // Scan and trigger status
  output trig_src_t              src_o,
  output logic                   ext_grant_o,
  output logic                   scan_active_o,
  output logic [CHAN_W-1:0]      channel_o,
  output logic                   close_pulse_o,
  output logic                   ext_out_pulse_o,
  output logic [7:0]             backplane_out_o,
  output trig_out_sel_t          out_sel_o
);

  err_entry_t            queue [ERR_DEPTH];
  logic [ERR_PTR_W-1:0]  rd_ptr;
  logic [ERR_PTR_W-1:0]  wr_ptr;
  logic [ERR_CNT_W-1:0]  count;
  src_sel_t              pending;
  src_sel_t              active;
  logic                  ext_busy_err;
  logic [1:0]            ext_sync;
  logic [1:0]            ext_prev;
  logic [7:0]            line_s1;
  logic [7:0]            line_s2;
  logic [7:0]            line_prev;
  scan_state_t           state;
  logic                  trig_event;
  logic                  do_push;
  logic                  do_pop;
  err_entry_t            push_val;

  function automatic logic [ERR_PTR_W-1:0] ptr_inc(input logic [ERR_PTR_W-1:0] p);
    return (p == PTR_LAST) ? PTR_ZERO : p + PTR_ONE;
  endfunction

  // Error sources: host reported or rejected busy external request
  assign do_push  = err_push_i | ext_busy_err;                              // [RL1]
  assign push_val = ext_busy_err ? err_entry_t'{num: ERR_NUM_EXT_BUSY, msg_id: MSG_ID_W, msg_len: MSG_ID_W}
                                 : err_entry_i;
  assign do_pop   = err_query_i && (count != '0);

  // Queue storage
  always_ff @(posedge clk_i) begin
    if (do_push && count < CNT_FULL) begin
      queue[wr_ptr] <= push_val;                                             // [RL1] [RL5]
    end else if (do_push && !do_pop) begin
      queue[(wr_ptr == PTR_ZERO) ? PTR_LAST : wr_ptr - PTR_ONE] <=
        '{num: ERR_NUM_OVERFLOW, msg_id: MSG_ID_OVERFLOW, msg_len: MSG_LEN_OVERFLOW};   // [RL6]
    end
  end

  // Queue pointers and count
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ptr <= PTR_ZERO;
      wr_ptr <= PTR_ZERO;
      count  <= '0;
    end else if (cls_cmd_i) begin
      rd_ptr <= PTR_ZERO;                                                    // [RL4]
      wr_ptr <= PTR_ZERO;
      count  <= '0;
    end else begin
      if (do_pop) begin
        rd_ptr <= ptr_inc(rd_ptr);                                           // [RL2]
      end
      if (do_push && count < CNT_FULL) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_push && count < CNT_FULL && !do_pop) begin
        count <= count + CNT_ONE;
      end else if (do_pop && !(do_push && count < CNT_FULL)) begin
        count <= count - CNT_ONE;
      end
    end
  end

  // Query answer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_valid_o <= 1'b0;
      err_entry_o <= '0;
      err_count_o <= '0;
    end else begin
      err_valid_o <= err_query_i;
      err_count_o <= cls_cmd_i ? '0 : count;
      if (err_query_i) begin
        err_entry_o <= do_pop ? queue[rd_ptr]                                // [RL2]
                              : err_entry_t'{ERR_NUM_NONE, MSG_ID_NONE, MSG_LEN_NONE}; // [RL3]
      end
    end
  end

  // Source selection, recorded then made active at arm
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pending      <= '{src: SRC_IMMEDIATE, line: '0};
      active       <= '{src: SRC_IMMEDIATE, line: '0};
      ext_grant_o  <= 1'b0;
      ext_busy_err <= 1'b0;
      src_o        <= SRC_IMMEDIATE;
    end else begin
      ext_busy_err <= 1'b0;
      src_o        <= active.src;
      if (rst_cmd_i) begin
        pending     <= '{src: SRC_IMMEDIATE, line: '0};                     // [RL18]
        active      <= '{src: SRC_IMMEDIATE, line: '0};
        ext_grant_o <= 1'b0;
      end else begin
        if (src_write_i) begin
          if (src_sel_i.src == SRC_EXTERNAL && ext_owned_i && ext_owner_i != box_id_i) begin
            ext_busy_err <= 1'b1;                                            // [RL14]
          end else begin
            pending <= src_sel_i;                                            // [RL10] [RL11]
            if (src_sel_i.src == SRC_EXTERNAL) begin
              ext_grant_o <= 1'b1;                                           // [RL12]
            end else if (src_sel_i.src != SRC_BACKPLANE) begin
              ext_grant_o <= 1'b0;                                           // [RL13]
            end
          end
        end
        if (scan_arm_cmd_i) begin
          active <= pending;                                                 // [RL11]
        end
      end
    end
  end

  // Pin synchronisers and edge memory
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_sync  <= 2'b00;
      ext_prev  <= 2'b00;
      line_s1   <= '0;
      line_s2   <= '0;
      line_prev <= '0;
    end else begin
      ext_sync  <= {ext_sync[0], ext_trig_pin_i};
      ext_prev  <= {ext_prev[0], ext_sync[1]};
      line_s1   <= backplane_line_source_i;
      line_s2   <= line_s1;
      line_prev <= line_s2;
    end
  end

  // Trigger event for the active source
  always_comb begin
    trig_event = 1'b0;
    case (active.src)
      SRC_BUS:       trig_event = bus_trig_i | sw_trig_i;                    // [RL7] [RL15]
      SRC_HOLD:      trig_event = sw_trig_i;                                 // [RL7] [RL9]
      SRC_EXTERNAL:  trig_event = ext_grant_o & ext_prev[0] & ~ext_prev[1];
      SRC_IMMEDIATE: trig_event = 1'b1;                                      // [RL20]
      SRC_BACKPLANE: trig_event = line_s2[active.line] & ~line_prev[active.line];
      default:       trig_event = 1'b0;
    endcase
  end

  // Scan sequencer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state         <= SCAN_IDLE;
      channel_o     <= '0;
      close_pulse_o <= 1'b0;
      scan_active_o <= 1'b0;
    end else begin
      close_pulse_o <= 1'b0;
      if (abort_i || rst_cmd_i) begin
        state         <= SCAN_IDLE;
        scan_active_o <= 1'b0;
      end else begin
        case (state)
          SCAN_IDLE: begin
            if (scan_arm_cmd_i && list_len_i != '0) begin                    // [RL8]
              state         <= SCAN_CLOSE;
              channel_o     <= '0;
              scan_active_o <= 1'b1;
            end
          end
          SCAN_CLOSE: begin
            close_pulse_o <= 1'b1;                                           // [RL19]
            state         <= SCAN_WAIT;
          end
          SCAN_WAIT: begin
            if (trig_event) begin
              if (channel_o + CHAN_ONE >= list_len_i) begin
                state         <= SCAN_IDLE;
                scan_active_o <= 1'b0;
              end else begin
                channel_o <= channel_o + CHAN_ONE;                           // [RL19]
                state     <= SCAN_CLOSE;
              end
            end
          end
          default: state <= SCAN_IDLE;
        endcase
      end
    end
  end

  // Output selection, one at a time
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_sel_o <= OUT_NONE;
    end else if (rst_cmd_i) begin
      out_sel_o <= OUT_NONE;
    end else if (out_write_i) begin
      out_sel_o <= out_sel_i;                                                // [RL17]
    end
  end

  // Output pulses on channel close
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_out_pulse_o <= 1'b0;
      backplane_out_o <= '0;
    end else begin
      ext_out_pulse_o <= close_pulse_o && out_sel_o == OUT_EXTERNAL;         // [RL16]
      backplane_out_o <= '0;
      if (close_pulse_o && out_sel_o == OUT_BACKPLANE) begin
        backplane_out_o[active.line] <= 1'b1;
      end
    end
  end

  property p_query_empty;
    @(posedge clk_i) disable iff (!reset_n_i)
    (err_query_i && count == '0) |=> err_valid_o && err_entry_o.num == ERR_NUM_NONE;
  endproperty
  a_query_empty: assert property (p_query_empty) else $error("Empty query not zero"); // [RL3]
  property p_pop_one;
    @(posedge clk_i) disable iff (!reset_n_i)
    (do_pop && !do_push && !cls_cmd_i) |=> count == $past(count) - CNT_ONE;
  endproperty
  a_pop_one: assert property (p_pop_one) else $error("Pop did not remove one"); // [RL2]
  property p_cls;
    @(posedge clk_i) disable iff (!reset_n_i) cls_cmd_i |=> count == '0;
  endproperty
  a_cls: assert property (p_cls) else $error("Clear left entries"); // [RL4]

  property p_cap;
    @(posedge clk_i) disable iff (!reset_n_i) count <= CNT_FULL;
  endproperty
  a_cap: assert property (p_cap) else $error("Queue above capacity"); // [RL5]

  property p_full_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    (count == CNT_FULL && do_push && !do_pop && !cls_cmd_i) |=> count == CNT_FULL;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("Overflow changed count"); // [RL6]

  property p_rst_src;
    @(posedge clk_i) disable iff (!reset_n_i) rst_cmd_i |=> active.src == SRC_IMMEDIATE;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("Reset not immediate"); // [RL18]

  property p_arm_only;
    @(posedge clk_i) disable iff (!reset_n_i)
    (!scan_arm_cmd_i && !rst_cmd_i) |=> active == $past(active);
  endproperty
  a_arm_only: assert property (p_arm_only) else $error("Source changed without arm"); // [RL11] [RL9]

  property p_busy_err;
    @(posedge clk_i) disable iff (!reset_n_i)
    (src_write_i && !rst_cmd_i && src_sel_i.src == SRC_EXTERNAL && ext_owned_i && ext_owner_i != box_id_i)
      |=> ext_busy_err ##0 $stable(ext_grant_o);
  endproperty
  a_busy_err: assert property (p_busy_err) else $error("Busy external not rejected"); // [RL14]

  property p_close_out;
    @(posedge clk_i) disable iff (!reset_n_i)
    (close_pulse_o && out_sel_o == OUT_EXTERNAL) |=> ext_out_pulse_o;
  endproperty
  a_close_out: assert property (p_close_out) else $error("No output pulse"); // [RL16]

  property p_arm_close;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == SCAN_IDLE && scan_arm_cmd_i && list_len_i != '0 && !abort_i && !rst_cmd_i)
      |=> ##1 close_pulse_o && channel_o == '0;
  endproperty
  a_arm_close: assert property (p_arm_close) else $error("First channel not closed"); // [RL19]

  c_overflow: cover property (@(posedge clk_i) disable iff (!reset_n_i) count == CNT_FULL && do_push);
  c_scan_done: cover property (@(posedge clk_i) disable iff (!reset_n_i) scan_active_o ##1 !scan_active_o);
  c_ext_reject: cover property (@(posedge clk_i) disable iff (!reset_n_i) ext_busy_err);

endmodule

// >>> hdl/scan_trig_pkg.sv
// Constants and types for the scan trigger and error queue block
package scan_trig_pkg;

  localparam int unsigned ERR_DEPTH     = 30;
  localparam int unsigned ERR_PTR_W     = 5;
  localparam int unsigned ERR_CNT_W     = 6;
  localparam int unsigned MSG_LEN_MAX   = 255;
  localparam int unsigned MSG_IDX_W     = 8;
  localparam int unsigned BOX_W         = 4;
  localparam int unsigned CHAN_W        = 8;
  localparam int unsigned LINE_W        = 3;

  localparam logic [15:0] ERR_NUM_NONE     = 16'h0000;
  localparam logic [15:0] ERR_NUM_OVERFLOW = 16'hFEA2;
  localparam logic [7:0]  MSG_ID_W         = 8'h08;
  localparam logic [7:0]  MSG_ID_NONE      = 8'h00;
  localparam logic [7:0]  MSG_ID_OVERFLOW  = 8'h01;

  localparam logic [ERR_PTR_W-1:0] PTR_LAST = 5'h1D;
  localparam logic [ERR_CNT_W-1:0] CNT_FULL = 6'h1E;
  localparam logic [ERR_PTR_W-1:0] PTR_ZERO = 5'h00;
  localparam logic [ERR_PTR_W-1:0] PTR_ONE  = 5'h01;
  localparam logic [ERR_CNT_W-1:0] CNT_ONE  = 6'h01;

  localparam logic [15:0] ERR_NUM_EXT_BUSY = 16'hFFD5;
  localparam logic [7:0]  MSG_LEN_NONE     = 8'h08;
  localparam logic [7:0]  MSG_LEN_OVERFLOW = 8'h0F;
  localparam logic [CHAN_W-1:0] CHAN_ONE   = 8'h01;

  typedef enum logic [2:0] {
    SRC_BUS       = 3'b000,
    SRC_EXTERNAL  = 3'b001,
    SRC_HOLD      = 3'b010,
    SRC_IMMEDIATE = 3'b011,
    SRC_BACKPLANE = 3'b100
  } trig_src_t;

  typedef enum logic [1:0] {
    OUT_NONE      = 2'b00,
    OUT_EXTERNAL  = 2'b01,
    OUT_BACKPLANE = 2'b10
  } trig_out_sel_t;

  typedef enum logic [1:0] {
    SCAN_IDLE    = 2'b00,
    SCAN_CLOSE   = 2'b01,
    SCAN_WAIT    = 2'b10
  } scan_state_t;

  // Error entry: number plus message handle
  typedef struct packed {
    logic [15:0] num;
    logic [7:0]  msg_id;
    logic [7:0]  msg_len;
  } err_entry_t;

  // Trigger source request: kind plus backplane line
  typedef struct packed {
    trig_src_t          src;
    logic [LINE_W-1:0]  line;
  } src_sel_t;

endpackage

// >>> testbench/scan_host.sv
// Host model issuing one-cycle command pulses to the switchbox block
`timescale 1ns/1ps
module scan_host
  import scan_trig_pkg::*;
(
  // Clock
  input  wire logic    clk_i,
  // Command pulses
  output logic         rst_cmd_o,
  output logic         cls_cmd_o,
  output logic         err_query_o,
  output logic         err_push_o,
  output logic         src_write_o,
  output logic         scan_arm_cmd_o,
  output logic         sw_trig_o,
  output logic         bus_trig_o,
  output logic         out_write_o,
  output logic         abort_o,
  // Command arguments
  output err_entry_t   err_entry_o,
  output src_sel_t     src_sel_o,
  output trig_out_sel_t out_sel_o
);
  logic [9:0] cmd = 10'h000;

  assign {abort_o, out_write_o, bus_trig_o, sw_trig_o, scan_arm_cmd_o, src_write_o, err_push_o, err_query_o,
          cls_cmd_o, rst_cmd_o} = cmd;

  initial begin
    err_entry_o = '0;
    src_sel_o   = '0;
    out_sel_o   = OUT_NONE;
  end

  // One command per pulse, changed only at falling edges
  task automatic pulse(input logic [9:0] m);
    @(negedge clk_i) cmd = m;
    @(negedge clk_i) cmd = 10'h000;
  endtask

  task automatic rst();   pulse(10'h001); endtask
  task automatic cls();   pulse(10'h002); endtask
  task automatic query(); pulse(10'h004); endtask
  task automatic push(input err_entry_t e); err_entry_o = e; pulse(10'h008); endtask
  task automatic src(input trig_src_t s, input logic [2:0] l); src_sel_o = '{s, l}; pulse(10'h010); endtask
  task automatic arm();   pulse(10'h020); endtask
  // Only used after a list length is set and the scan is armed
  task automatic trig_sw(); pulse(10'h040); endtask
  // Bus trigger command for the bus source
  task automatic trig_bus(); pulse(10'h080); endtask
  task automatic outsel(input trig_out_sel_t o); out_sel_o = o; pulse(10'h100); endtask
  task automatic abort(); pulse(10'h200); endtask
endmodule

// >>> testbench/scan_trigger_and_error_queue_tb.sv
// Self-checking bench for the error queue and scan trigger block
`timescale 1ns/1ps
module scan_trigger_and_error_queue_tb;
  import scan_trig_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, ext_pin = 1'b0, ext_owned = 1'b0;
  logic rst_cmd, cls_cmd, err_query, err_push, src_write, arm, sw_trig, bus_trig, out_write, abort;
  logic [7:0] list_len = 8'h04, bp = 8'h00, channel_o, backplane_out_o;
  logic [3:0] box_id = 4'h1, ext_owner = 4'h2;
  logic [5:0] err_count_o;
  logic err_valid_o, ext_grant_o, scan_active_o, close_pulse_o, ext_out_pulse_o;
  err_entry_t err_entry, err_entry_o;
  src_sel_t src_sel;
  trig_out_sel_t out_sel, out_sel_o;
  trig_src_t src_o;
  int failures = 0, checked = 0, closes = 0, ext_pulses = 0, bp_pulses = 0, c0, e0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (close_pulse_o === 1'b1) closes++;
    if (ext_out_pulse_o === 1'b1) ext_pulses++;
    if (backplane_out_o === 8'h01) bp_pulses++;
  end

  scan_host u_scan_host (.clk_i(clk_i), .rst_cmd_o(rst_cmd), .cls_cmd_o(cls_cmd), .err_query_o(err_query),
    .err_push_o(err_push), .src_write_o(src_write), .scan_arm_cmd_o(arm), .sw_trig_o(sw_trig),
    .bus_trig_o(bus_trig), .out_write_o(out_write), .abort_o(abort), .err_entry_o(err_entry),
    .src_sel_o(src_sel), .out_sel_o(out_sel));

  scan_trigger_and_error_queue u_scan_trigger_and_error_queue (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .rst_cmd_i(rst_cmd), .cls_cmd_i(cls_cmd), .err_query_i(err_query), .err_push_i(err_push),
    .err_entry_i(err_entry), .src_write_i(src_write), .src_sel_i(src_sel), .scan_arm_cmd_i(arm),
    .sw_trig_i(sw_trig), .bus_trig_i(bus_trig), .abort_i(abort), .list_len_i(list_len),
    .out_write_i(out_write), .out_sel_i(out_sel), .box_id_i(box_id), .ext_owned_i(ext_owned),
    .ext_owner_i(ext_owner), .ext_trig_pin_i(ext_pin), .backplane_line_source_i(bp),
    .err_valid_o(err_valid_o), .err_entry_o(err_entry_o), .err_count_o(err_count_o), .src_o(src_o),
    .ext_grant_o(ext_grant_o), .scan_active_o(scan_active_o), .channel_o(channel_o),
    .close_pulse_o(close_pulse_o), .ext_out_pulse_o(ext_out_pulse_o), .backplane_out_o(backplane_out_o),
    .out_sel_o(out_sel_o));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Rising edge on the trigger pins, held three cycles
  task automatic edge_in(input logic e, input logic [7:0] b);
    @(negedge clk_i) begin
      ext_pin = e;
      bp = b;
    end
    idle(3);
    ext_pin = 1'b0;
    bp = 8'h00;
    idle(4);
  endtask

  task automatic t_queue();
    u_scan_host.query();
    check(err_valid_o, 1'b1);
    check(err_entry_o, {ERR_NUM_NONE, MSG_ID_NONE, 8'h08});
    for (int i = 1; i <= 3; i++) u_scan_host.push({16'h0100 + 16'(i), 8'h10, 8'hFF});
    idle(1);
    check(err_count_o, 6'h03);
    for (int i = 1; i <= 3; i++) begin
      u_scan_host.query();
      check(err_entry_o, {16'h0100 + 16'(i), 8'h10, 8'hFF});
    end
    idle(1);
    check(err_count_o, 6'h00);
    $display("queue test done");
  endtask

  task automatic t_overflow();
    for (int i = 0; i < 31; i++) u_scan_host.push({16'h0200 + 16'(i), 8'h20, 8'h04});
    check(err_count_o, CNT_FULL);
    for (int i = 0; i < 29; i++) begin
      u_scan_host.query();
      check(err_entry_o[31:16], 16'h0200 + 16'(i));
    end
    u_scan_host.query();
    check(err_entry_o, {ERR_NUM_OVERFLOW, MSG_ID_OVERFLOW, 8'h0F});
    u_scan_host.push({16'h0300, 8'h30, 8'h01});
    u_scan_host.push({16'h0301, 8'h30, 8'h01});
    u_scan_host.cls();
    check(err_count_o, 6'h00);
    u_scan_host.query();
    check(err_entry_o[31:16], ERR_NUM_NONE);
    $display("overflow test done");
  endtask

  task automatic t_hold_bus();
    c0 = closes;
    u_scan_host.src(SRC_HOLD, 3'h0);
    check(scan_active_o, 1'b0);
    u_scan_host.arm();
    idle(4);
    check({scan_active_o, channel_o}, {1'b1, 8'h00});
    check(src_o, SRC_HOLD);
    u_scan_host.trig_sw();
    idle(4);
    check(channel_o, 8'h01);
    u_scan_host.src(SRC_BUS, 3'h0);
    u_scan_host.trig_bus();
    idle(4);
    check(channel_o, 8'h01);
    check(src_o, SRC_HOLD);
    u_scan_host.trig_sw();
    idle(4);
    check(channel_o, 8'h02);
    u_scan_host.arm();
    u_scan_host.trig_bus();
    idle(4);
    check(channel_o, 8'h03);
    check(src_o, SRC_BUS);
    u_scan_host.trig_bus();
    idle(4);
    check(scan_active_o, 1'b0);
    check(closes - c0, 4);
    $display("hold and bus test done");
  endtask

  task automatic t_immediate();
    u_scan_host.outsel(OUT_EXTERNAL);
    check(out_sel_o, OUT_EXTERNAL);
    c0 = closes;
    e0 = ext_pulses;
    u_scan_host.src(SRC_IMMEDIATE, 3'h0);
    u_scan_host.arm();
    idle(40);
    check(scan_active_o, 1'b0);
    check(closes - c0, 4);
    check(ext_pulses - e0, 4);
    u_scan_host.outsel(OUT_BACKPLANE);
    check(out_sel_o, OUT_BACKPLANE);
    e0 = ext_pulses;
    c0 = bp_pulses;
    u_scan_host.arm();
    idle(40);
    check(ext_pulses - e0, 0);
    check(bp_pulses - c0, 4);
    $display("immediate test done");
  endtask

  task automatic t_external();
    ext_owned = 1'b1;
    u_scan_host.src(SRC_EXTERNAL, 3'h0);
    idle(3);
    check({ext_grant_o, err_count_o}, {1'b0, 6'h01});
    u_scan_host.query();
    check(err_entry_o[31:16], ERR_NUM_EXT_BUSY);
    ext_owned = 1'b0;
    u_scan_host.src(SRC_EXTERNAL, 3'h0);
    idle(2);
    check(ext_grant_o, 1'b1);
    u_scan_host.arm();
    idle(4);
    u_scan_host.trig_sw();
    idle(2);
    check(channel_o, 8'h00);
    edge_in(1'b1, 8'h00);
    check(channel_o, 8'h01);
    u_scan_host.src(SRC_BACKPLANE, 3'h5);
    check(ext_grant_o, 1'b1);
    u_scan_host.arm();
    edge_in(1'b0, 8'h20);
    check(channel_o, 8'h02);
    u_scan_host.src(SRC_HOLD, 3'h0);
    idle(2);
    check(ext_grant_o, 1'b0);
    u_scan_host.abort();
    idle(2);
    check(scan_active_o, 1'b0);
    u_scan_host.rst();
    idle(2);
    check({out_sel_o, scan_active_o}, {OUT_NONE, 1'b0});
    check(src_o, SRC_IMMEDIATE);
    c0 = closes;
    u_scan_host.arm();
    idle(40);
    check(closes - c0, 4);
    $display("external test done");
  endtask

  task automatic give_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    give_verdict();
  end

  initial begin
    idle(4);
    reset_n_i = 1'b1;
    t_queue();
    t_overflow();
    t_hold_bus();
    t_immediate();
    t_external();
    give_verdict();
  end
endmodule
